// ---- sarr_defs.vh ----
// Constants for the converter start and serial readout logic
`ifndef SARR_DEFS_VH
`define SARR_DEFS_VH

// Result word
`define SARR_RES_BITS 16
`define SARR_MSB 15
`define SARR_CODE_MAX 16'h7FFF
`define SARR_CODE_MIN 16'h8000
`define SARR_CODE_FLIP 16'h8000
`define SARR_RESULT_RST 16'h0000

// Chain delay in shift clock cycles
`define SARR_CHAIN_DELAY 16

// Timing
`define SARR_CLK_PERIOD_NS 10
`define SARR_TCONV_MIN_NS 500
`define SARR_TCONV_MAX_NS 1600
`define SARR_TCONV_MIN_CYC ((`SARR_TCONV_MIN_NS + `SARR_CLK_PERIOD_NS - 1) / `SARR_CLK_PERIOD_NS)
`define SARR_TCONV_MAX_CYC (`SARR_TCONV_MAX_NS / `SARR_CLK_PERIOD_NS)
`define SARR_STEP_CYC 6

// Conversion states
`define SARR_ST_IDLE 2'h0
`define SARR_ST_CONV 2'h1
`define SARR_ST_READY 2'h2

// Interface modes
`define SARR_MODE_SELECT 1'h0
`define SARR_MODE_CHAIN 1'h1

`endif

// ---- sarr_sync.v ----
// Two-flop synchronisers, one per input bit
`timescale 1ns/1ps
module sarr_sync #(
  parameter WIDTH = 3
) (
  input wire i_clock,
  input wire i_rst_n,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  genvar g;

  // ==========================================================
  // Per-bit synchroniser
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_ff;
      reg sync_ff;
      always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= i_async[g];
          sync_ff <= meta_ff;
        end
      end
      assign o_sync[g] = sync_ff;
    end
  endgenerate

endmodule

// ---- sarr_top.v ----
// Conversion start, successive approximation and serial readout of the converter
`timescale 1ns/1ps
`include "sarr_defs.vh"
// Summary of operation
// - Convert rising edge while not converting starts conversion and latches chain or select mode.
// - Input level is held from the convert rising edge for that conversion.
// - Select mode drives the serial output only while convert or serial input is low.
// - Result leaves on the serial output, stepping with the host shift clock.
// - While selected, each shift clock cycle after any busy bit advances the result one bit, up to sixteen bits.
// - Serial input low at convert rising edge selects chain mode.
// - Chain mode passes the upstream result stream through onto one line.
// - Chain input reappears on the output sixteen shift clocks later.
// - Serial input high at convert rising edge selects select mode.
// - Select mode enables the output while serial input or convert is low, until sixteen result bits are shifted out.
// - Select mode with either line low at completion gives busy indication.
// - Conversion completes between 0.5 and 1.6 us after convert edge.
// - Result starts with bit fifteen, valid in the ready state with the output enabled and any busy bit clocked out.
// - Two's-complement result saturating at 7FFF and 8000.
// - Conversion runs from the internal clock, not the shift clock.
module sarr_top #(
  parameter AIN_BITS = 18,
  parameter STEP_CYCLES = `SARR_STEP_CYC
) (
  input wire I_CLOCK,
  input wire I_RST_N,
  input wire I_CONVERT_START,
  input wire I_SHIFT_CLOCK,
  input wire I_SERIAL_CHAIN_IN,
  input wire signed [AIN_BITS-1:0] I_ANALOG_LEVEL,
  output wire O_SERIAL_RESULT_OUT,
  output wire O_SERIAL_RESULT_OE,
  output wire O_CHAIN_MODE,
  output wire O_CONVERTING
);

  localparam RB = `SARR_RES_BITS;
  localparam [3:0] LAST_BIT = 4'hF;
  localparam [4:0] CHAIN_LEN = `SARR_CHAIN_DELAY;
  localparam [7:0] STEP_LAST = STEP_CYCLES[7:0] - 8'h01;
  localparam signed [AIN_BITS-1:0] AIN_MAX = 32767;
  localparam signed [AIN_BITS-1:0] AIN_MIN = -32768;

  // ==========================================================
  // Pin synchronisation
  wire [2:0] sync_in;
  wire [2:0] sync_out;
  wire cnv_s;
  wire sck_s;
  wire sdi_s;

  assign sync_in = {I_SERIAL_CHAIN_IN, I_SHIFT_CLOCK, I_CONVERT_START};

  sarr_sync #(
    .WIDTH(3)
  ) u_sync (
    .i_clock(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_async(sync_in),
    .o_sync(sync_out)
  );

  assign cnv_s = sync_out[0];
  assign sck_s = sync_out[1];
  assign sdi_s = sync_out[2];

  // ==========================================================
  // Edge detection
  reg cnv_prev_ff;
  reg sck_prev_ff;
  wire cnv_rise;
  wire sck_fall;

  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cnv_prev_ff <= 1'b0;
      sck_prev_ff <= 1'b0;
    end else begin
      cnv_prev_ff <= cnv_s;
      sck_prev_ff <= sck_s;
    end
  end

  assign cnv_rise = cnv_s & ~cnv_prev_ff;
  assign sck_fall = sck_prev_ff & ~sck_s;

  // ==========================================================
  // Conversion control
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg mode_ff;
  reg [7:0] step_cnt_ff;
  reg [3:0] bit_idx_ff;
  reg nxt_mode;
  reg [7:0] nxt_step_cnt;
  reg [3:0] nxt_bit_idx;
  wire start_conv;
  wire step_done;
  wire conv_done;
  wire sel_en;

  assign start_conv = cnv_rise & (state_ff != `SARR_ST_CONV);
  assign step_done = (state_ff == `SARR_ST_CONV) && (step_cnt_ff == STEP_LAST);
  assign conv_done = step_done && (bit_idx_ff == 4'h0);
  assign sel_en = ~cnv_s | ~sdi_s;

  always @* begin
    case (state_ff)
      `SARR_ST_IDLE: begin
        nxt_state = start_conv ? `SARR_ST_CONV : `SARR_ST_IDLE;
      end
      `SARR_ST_CONV: begin
        nxt_state = conv_done ? `SARR_ST_READY : `SARR_ST_CONV;
      end
      `SARR_ST_READY: begin
        nxt_state = start_conv ? `SARR_ST_CONV : `SARR_ST_READY;
      end
      default: begin
        nxt_state = `SARR_ST_IDLE;
      end
    endcase
  end

  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_ff <= `SARR_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Mode latch on the convert rising edge
  always @* begin
    nxt_mode = mode_ff;
    if (start_conv) begin
      nxt_mode = sdi_s ? `SARR_MODE_SELECT : `SARR_MODE_CHAIN;
    end
  end

  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mode_ff <= `SARR_MODE_SELECT;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Internal conversion timing
  always @* begin
    nxt_step_cnt = step_cnt_ff;
    nxt_bit_idx = bit_idx_ff;
    if (start_conv) begin
      nxt_step_cnt = 8'h00;
      nxt_bit_idx = LAST_BIT;
    end else if (state_ff == `SARR_ST_CONV) begin
      if (step_done) begin
        nxt_step_cnt = 8'h00;
        nxt_bit_idx = bit_idx_ff - 4'h1;
      end else begin
        nxt_step_cnt = step_cnt_ff + 8'h01;
      end
    end
  end

  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      step_cnt_ff <= 8'h00;
      bit_idx_ff <= LAST_BIT;
    end else begin
      step_cnt_ff <= nxt_step_cnt;
      bit_idx_ff <= nxt_bit_idx;
    end
  end

  // ==========================================================
  // Sample and successive approximation
  reg [RB-1:0] target_ff;
  reg [RB-1:0] sar_ff;
  reg [RB-1:0] nxt_target;
  reg [RB-1:0] nxt_sar;
  reg [RB-1:0] sat_code;
  wire [RB-1:0] trial;
  wire [RB-1:0] bit_mask;
  wire [RB-1:0] final_code;

  always @* begin
    if (I_ANALOG_LEVEL > AIN_MAX) begin
      sat_code = `SARR_CODE_MAX;
    end else if (I_ANALOG_LEVEL < AIN_MIN) begin
      sat_code = `SARR_CODE_MIN;
    end else begin
      sat_code = I_ANALOG_LEVEL[RB-1:0];
    end
  end

  assign bit_mask = {{(RB-1){1'b0}}, 1'b1} << bit_idx_ff;
  assign trial = sar_ff | bit_mask;
  // Code left after the last trial step
  assign final_code = (trial <= target_ff) ? trial : sar_ff;

  // One trial bit per step, most significant first
  always @* begin
    nxt_target = target_ff;
    nxt_sar = sar_ff;
    if (start_conv) begin
      nxt_target = sat_code ^ `SARR_CODE_FLIP;
      nxt_sar = `SARR_RESULT_RST;
    end else if (step_done && (trial <= target_ff)) begin
      nxt_sar = trial;
    end
  end

  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      target_ff <= `SARR_RESULT_RST;
      sar_ff <= `SARR_RESULT_RST;
    end else begin
      target_ff <= nxt_target;
      sar_ff <= nxt_sar;
    end
  end

  // ==========================================================
  // Serial readout
  reg [RB-1:0] shift_ff;
  reg [4:0] shift_cnt_ff;
  reg busy_pend_ff;
  reg read_done_ff;

  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      shift_ff <= `SARR_RESULT_RST;
      shift_cnt_ff <= 5'h00;
      busy_pend_ff <= 1'b0;
      read_done_ff <= 1'b0;
    end else if (start_conv) begin
      shift_cnt_ff <= 5'h00;
      busy_pend_ff <= 1'b0;
      read_done_ff <= 1'b0;
    end else if (conv_done) begin
      shift_ff <= final_code ^ `SARR_CODE_FLIP;
      busy_pend_ff <= (mode_ff == `SARR_MODE_SELECT) && sel_en;
    end else if ((state_ff == `SARR_ST_READY) && sck_fall) begin
      if (mode_ff == `SARR_MODE_CHAIN) begin
        shift_ff <= {shift_ff[RB-2:0], sdi_s};
      end else if (sel_en && busy_pend_ff) begin
        busy_pend_ff <= 1'b0;
      end else if (sel_en && !read_done_ff) begin
        shift_ff <= {shift_ff[RB-2:0], 1'b0};
        shift_cnt_ff <= shift_cnt_ff + 5'h01;
        if (shift_cnt_ff == CHAIN_LEN - 5'h01) begin
          read_done_ff <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Output pin
  reg sdo_ff;
  reg oe_ff;
  reg nxt_sdo;
  reg nxt_oe;

  always @* begin
    nxt_sdo = 1'b0;
    nxt_oe = 1'b0;
    if (mode_ff == `SARR_MODE_CHAIN) begin
      nxt_oe = 1'b1;
      nxt_sdo = (state_ff == `SARR_ST_READY) ? shift_ff[`SARR_MSB] : 1'b0;
    end else if (sel_en && !read_done_ff) begin
      nxt_oe = 1'b1;
      if (state_ff == `SARR_ST_CONV) begin
        nxt_sdo = 1'b0;
      end else if (busy_pend_ff) begin
        nxt_sdo = 1'b1;
      end else if (state_ff == `SARR_ST_READY) begin
        nxt_sdo = shift_ff[`SARR_MSB];
      end
    end else begin
      nxt_oe = 1'b0;
    end
  end

  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sdo_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      sdo_ff <= nxt_sdo;
      oe_ff <= nxt_oe;
    end
  end

  assign O_SERIAL_RESULT_OUT = sdo_ff;
  assign O_SERIAL_RESULT_OE = oe_ff;
  assign O_CHAIN_MODE = mode_ff;
  assign O_CONVERTING = (state_ff == `SARR_ST_CONV);

endmodule

// ---- sarr_asserts.sv ----
// Checker on the converter readout ports
`timescale 1ns/1ps
module sarr_asserts #(
  parameter STEP_CYCLES = 6
) (
  input wire I_CLOCK,
  input wire I_RST_N,
  input wire I_CONVERT_START,
  input wire I_SHIFT_CLOCK,
  input wire I_SERIAL_CHAIN_IN,
  input wire O_SERIAL_RESULT_OUT,
  input wire O_SERIAL_RESULT_OE,
  input wire O_CHAIN_MODE,
  input wire O_CONVERTING
);
  // ==========
  // Cycle counters
  reg [11:0] conv_ff;
  reg [3:0] quiet_ff;
  reg sck_ff;
  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      conv_ff <= 12'h000;
      quiet_ff <= 4'hF;
      sck_ff <= 1'b0;
    end else begin
      conv_ff <= O_CONVERTING ? conv_ff + 12'h001 : 12'h000;
      quiet_ff <= (O_CONVERTING || (sck_ff && !I_SHIFT_CLOCK)) ? 4'h0 :
        quiet_ff + {3'h0, quiet_ff != 4'hF};
      sck_ff <= I_SHIFT_CLOCK;
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_N);
  a_start_lat:
    assert property ($rose(I_CONVERT_START) && !O_CONVERTING |-> ##[2:4] O_CONVERTING)
    else $error("convert edge ignored");
  a_mode_latch:
    assert property ($rose(O_CONVERTING) |-> O_CHAIN_MODE == !$past(I_SERIAL_CHAIN_IN, 3))
    else $error("wrong mode");
  a_conv_len:
    assert property ($fell(O_CONVERTING) |-> conv_ff == 16 * STEP_CYCLES)
    else $error("wrong conversion length");
  a_chain_oe:
    assert property (O_CHAIN_MODE && $past(O_CHAIN_MODE, 2) |-> O_SERIAL_RESULT_OE)
    else $error("chain output off");
  a_sel_off:
    assert property ((!O_CHAIN_MODE && I_CONVERT_START && I_SERIAL_CHAIN_IN) [*5]
      |-> !O_SERIAL_RESULT_OE)
    else $error("output not released");
  a_busy_low:
    assert property (O_CONVERTING && $past(O_CONVERTING, 2) && O_SERIAL_RESULT_OE
      |-> !O_SERIAL_RESULT_OUT)
    else $error("output high while converting");
  a_busy_rise:
    assert property ($fell(O_CONVERTING) && !O_CHAIN_MODE && O_SERIAL_RESULT_OE
      |-> ##[0:2] O_SERIAL_RESULT_OUT)
    else $error("busy not raised");
  a_shift_step:
    assert property (O_SERIAL_RESULT_OE && $past(O_SERIAL_RESULT_OE)
      && $changed(O_SERIAL_RESULT_OUT) |-> quiet_ff <= 4'h6)
    else $error("output moved off shift fall");
endmodule
bind sarr_top sarr_asserts #(.STEP_CYCLES(STEP_CYCLES)) u_sarr_asserts (.I_CLOCK(I_CLOCK),
  .I_RST_N(I_RST_N), .I_CONVERT_START(I_CONVERT_START), .I_SHIFT_CLOCK(I_SHIFT_CLOCK),
  .I_SERIAL_CHAIN_IN(I_SERIAL_CHAIN_IN), .O_SERIAL_RESULT_OUT(O_SERIAL_RESULT_OUT),
  .O_SERIAL_RESULT_OE(O_SERIAL_RESULT_OE), .O_CHAIN_MODE(O_CHAIN_MODE),
  .O_CONVERTING(O_CONVERTING));

// ---- sarr_host.sv ----
// Host model driving convert, shift clock and chain input
`timescale 1ns/1ps
module sarr_host (
  input wire i_clock,
  input wire i_sdo_line,
  output reg o_convert_start = 1'b0,
  output reg o_shift_clock = 1'b0,
  output reg o_serial_chain_in = 1'b1,
  output reg o_done = 1'b0,
  output reg [31:0] o_word = 32'h0
);
  integer k;
  // ==========
  // Start: mode 0 select, 1 busy by convert, 2 busy by chain input, 3 chain
  task start(input integer mode);
    begin
      o_convert_start <= 1'b0;
      o_serial_chain_in <= (mode != 3);
      repeat (6) @(posedge i_clock);
      o_convert_start <= 1'b1;
      repeat (12) @(posedge i_clock);
      o_convert_start <= (mode == 2);
      o_serial_chain_in <= (mode < 2);
      repeat (4) @(posedge i_clock);
      o_convert_start <= (mode != 1);
      repeat (160) @(posedge i_clock);
      o_convert_start <= (mode > 1);
      repeat (5) @(posedge i_clock);
    end
  endtask
  // ==========
  // Readout, shift clock only within frames
  task read(input integer n, input [15:0] up);
    begin
      o_word = 32'h0;
      for (k = 0; k < n; k = k + 1) begin
        #62.5 o_shift_clock = 1'b1;
        o_word = {o_word[30:0], i_sdo_line};
        if (n == 32 && k < 16) o_serial_chain_in <= up[15 - k];
        #62.5 o_shift_clock = 1'b0;
      end
      #100 o_done = 1'b1;
      #10 o_done = 1'b0;
    end
  endtask
endmodule

// ---- test_sarr_top.sv ----
// Self-checking bench for the converter start and readout
`timescale 1ns/1ps
module test_sarr_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg signed [17:0] level = 18'sh00000;
  wire convert_start, sck, serial_chain_in, serial_result_out, sdo_oe, done, chain, conv_on;
  wire [31:0] word;
  wire sdo_line = sdo_oe ? serial_result_out : 1'bz;
  integer fails = 0;
  integer n_checks = 0;
  integer cycles = 0;
  integer seed = 18491;
  integer i;
  reg [15:0] up;
  reg [15:0] code;
  reg signed [17:0] lv;
  reg signed [17:0] lvs [0:5] = '{18'sh09C40, 18'sh363C0, 18'sh07FFF, 18'sh38000,
    18'sh00000, 18'sh3FFFF};
  reg [31:0] exp_q [$];
  always #5 clk = ~clk;
  sarr_top u_sarr_top (.I_CLOCK(clk), .I_RST_N(rst_n), .I_CONVERT_START(convert_start),
    .I_SHIFT_CLOCK(sck), .I_SERIAL_CHAIN_IN(serial_chain_in), .I_ANALOG_LEVEL(level),
    .O_SERIAL_RESULT_OUT(serial_result_out), .O_SERIAL_RESULT_OE(sdo_oe), .O_CHAIN_MODE(chain),
    .O_CONVERTING(conv_on));
  sarr_host u_sarr_host (.i_clock(clk), .i_sdo_line(sdo_line), .o_convert_start(convert_start),
    .o_shift_clock(sck), .o_serial_chain_in(serial_chain_in), .o_done(done), .o_word(word));
  // ==========
  // Checking and verdict
  function [15:0] sat(input signed [17:0] a);
    sat = (a > 18'sh07FFF) ? 16'h7FFF : (a < 18'sh38000) ? 16'h8000 : a[15:0];
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] want);
    begin
      n_checks = n_checks + 1;
      if (seen !== want) begin
        fails = fails + 1;
        $display("MISMATCH %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (fails == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  always @(posedge done) check(word, exp_q.pop_front());
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  // ==========
  // Stimulus
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      lv = (i < 6) ? lvs[i] : 18'($random(seed));
      up = 16'($random(seed));
      code = sat(lv);
      exp_q.push_back((i % 4 == 3) ? {code, up} : {15'h0, i % 4 != 0, code});
      @(posedge clk);
      level <= lv;
      fork
        u_sarr_host.start(i % 4);
        begin
          repeat (12) @(posedge clk);
          level <= 18'($random(seed));
        end
      join
      check({31'h0, chain}, {31'h0, i % 4 == 3});
      check({31'h0, conv_on}, 32'h0);
      u_sarr_host.read((i % 4 == 3) ? 32 : (i % 4 == 0) ? 16 : 17, up);
    end
    repeat (20) @(posedge clk);
    report_and_stop;
  end
endmodule
